// *** verilog/mis_pkg.sv ***
package mis_pkg;

  // system clock and bus-lock timeout
  localparam int unsigned SYS_CLK_HZ     = 50_000_000;
  localparam int unsigned BUS_TIMEOUT_MS = 28;
  localparam int unsigned TIMEOUT_CYCLES = SYS_CLK_HZ / 1000 * BUS_TIMEOUT_MS;
  localparam int unsigned TIMEOUT_W      = 21;

  // slave address: fixed top bits, then high pin code, then low pin code
  localparam logic [2:0] ADDR_FIXED = 3'h4;
  localparam logic [6:0] ADDR_RESET = 7'h40;

  // special bytes seen on the bus
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] GCALL_WRITE = 8'h00;
  localparam logic [7:0] GCALL_RESET = 8'h06;

  // reset values
  localparam logic [7:0]  PTR_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // bit counter positions within a nine-clock byte frame
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  // events passed from the link domain as toggles
  localparam int unsigned EV_PTR = 0;
  localparam int unsigned EV_WR  = 1;
  localparam int unsigned EV_HS  = 2;
  localparam int unsigned EV_GC  = 3;
  localparam int unsigned EV_N   = 4;

  typedef enum logic [3:0] {
    ST_ADDR,
    ST_PTR,
    ST_DATA_HI,
    ST_DATA_LO,
    ST_GC,
    ST_RD_ADR,
    ST_RD_HI,
    ST_RD_LO,
    ST_IGNORE
  } mis_state_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  ptr;
    logic [15:0] data;
  } mis_wr_req_t;

endpackage

// *** verilog/mis_slave_port.sv ***
// Operation
// - a START (SDA falls while SCL high) begins reception of an address byte
// - address byte shifted in on rising SCL, msb first, seven bits then direction
// - on own address the device pulls SDA low during the ninth clock
// - SDA changing while SCL is high is taken as START or STOP
// - a STOP (SDA rises while SCL high) returns the port to idle
// - a 28 ms bus-lock timeout resets the serial interface logic
// - address is 100, high pin code, low pin code; pins code 00..11
// - both select pins are resampled at every transaction
// - the device is only a target: never drives SCL, START or STOP
// - works from 1 kHz up to 400 kHz and 3.4 MHz in high-speed mode
// - 16-bit words cross the bus upper byte first, then lower byte
// - first byte after a write address loads the register pointer
// - next two bytes are written to the pointed register, each acknowledged
// - START or STOP during a write abandons the write sequence
// - address plus pointer byte alone is accepted as a pointer update
// - a read returns upper byte, then lower byte after master acknowledge
// - master NACK, START or STOP ends a read and SDA is released
// - the pointer survives reads until a later write changes it
// - master code 00001XXX is not acknowledged but selects high-speed filters
// - after the master code, repeated STARTs keep the bus in high-speed mode
// - a STOP leaves high-speed mode and restores normal filter settings
// - SCL or SDA held low over 28 ms resets the serial interface
// - a general call reset clears the pointer and high-speed mode and pulses soft_reset
`timescale 1ns/100ps

module mis_slave_port #(
  parameter int unsigned TIMEOUT_CYCLES = mis_pkg::TIMEOUT_CYCLES
) (
  // system side
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // serial bus; scl also clocks the link logic
  input  wire logic                 scl,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n,
  // address strap pins
  input  wire logic                 addr_select_low_pin,
  input  wire logic                 addr_select_high_pin,
  // register file side
  output logic [7:0]                reg_ptr,
  input  wire logic [15:0]          rd_data,
  output mis_pkg::mis_wr_req_t      reg_wr,
  // mode and reset
  output logic                      hs_mode,
  output logic                      soft_reset
);

  localparam logic [mis_pkg::TIMEOUT_W-1:0] TO_LAST =
    mis_pkg::TIMEOUT_W'(TIMEOUT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // link domain
  mis_pkg::mis_state_t            state;
  mis_pkg::mis_state_t            next_state;
  logic [3:0]                     bit_cnt;
  logic [7:0]                     shreg;
  logic [7:0]                     byte_in;
  logic                           ack_pend;
  logic                           next_ack;
  logic                           ptr_load;
  logic                           wr_fire;
  logic                           hs_fire;
  logic                           gc_fire;
  logic [7:0]                     ptr;
  logic [7:0]                     wr_hi;
  logic [15:0]                    wr_data;
  logic [mis_pkg::EV_N-1:0]       ev_tog;
  logic [7:0]                     tx_sh;
  logic [7:0]                     tx_byte;

  // system domain
  logic [3:0]                     pin_s1;
  logic [3:0]                     pin_s2;
  logic [3:0]                     pin_s3;
  logic                           scl_s;
  logic                           sda_s;
  logic                           scl_p;
  logic                           sda_p;
  logic                           start_det;
  logic                           stop_det;
  logic                           scl_rise;
  logic [mis_pkg::EV_N-1:0]       ev_s1;
  logic [mis_pkg::EV_N-1:0]       ev_s2;
  logic [mis_pkg::EV_N-1:0]       ev_s3;
  logic [mis_pkg::EV_N-1:0]       ev_pulse;
  logic [1:0]                     sel_a;
  logic                           want_b;
  logic [6:0]                     own_addr;
  logic [mis_pkg::TIMEOUT_W-1:0]  low_cnt;
  logic                           bus_low;
  logic                           to_fire;
  logic                           link_clr;
  logic                           link_por;
  logic [15:0]                    rd_snap;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: byte engine on rising scl

  assign byte_in = {shreg[6:0], sda_in};

  always_comb begin
    next_state = state;
    next_ack   = 1'b0;
    ptr_load   = 1'b0;
    wr_fire    = 1'b0;
    hs_fire    = 1'b0;
    gc_fire    = 1'b0;
    if (bit_cnt == mis_pkg::BIT_LAST) begin
      case (state)
        mis_pkg::ST_ADDR: begin
          if (byte_in[7:1] == own_addr) begin
            next_ack   = 1'b1;
            next_state = byte_in[0] ? mis_pkg::ST_RD_ADR : mis_pkg::ST_PTR;
          end else if (byte_in[7:3] == mis_pkg::HS_CODE_TOP) begin
            hs_fire    = 1'b1;
            next_state = mis_pkg::ST_IGNORE;
          end else if (byte_in == mis_pkg::GCALL_WRITE) begin
            next_ack   = 1'b1;
            next_state = mis_pkg::ST_GC;
          end else begin
            next_state = mis_pkg::ST_IGNORE;
          end
        end
        mis_pkg::ST_PTR: begin
          next_ack   = 1'b1;
          ptr_load   = 1'b1;
          next_state = mis_pkg::ST_DATA_HI;
        end
        mis_pkg::ST_DATA_HI: begin
          next_ack   = 1'b1;
          next_state = mis_pkg::ST_DATA_LO;
        end
        mis_pkg::ST_DATA_LO: begin
          next_ack   = 1'b1;
          wr_fire    = 1'b1;
          next_state = mis_pkg::ST_IGNORE;
        end
        mis_pkg::ST_GC: begin
          next_ack   = (byte_in == mis_pkg::GCALL_RESET);
          gc_fire    = (byte_in == mis_pkg::GCALL_RESET);
          next_state = mis_pkg::ST_IGNORE;
        end
        default: begin
        end
      endcase
    end else if (bit_cnt == mis_pkg::BIT_ACK) begin
      case (state)
        mis_pkg::ST_RD_ADR: next_state = mis_pkg::ST_RD_HI;
        mis_pkg::ST_RD_HI:  next_state = sda_in ? mis_pkg::ST_IGNORE
                                                : mis_pkg::ST_RD_LO;
        mis_pkg::ST_RD_LO:  next_state = mis_pkg::ST_IGNORE;
        default:            next_state = state;
      endcase
    end
  end

  // cleared by every START, STOP or timeout, so a broken transfer is dropped
  always_ff @(posedge scl or posedge link_clr) begin
    if (link_clr) begin
      state    <= mis_pkg::ST_ADDR;
      bit_cnt  <= mis_pkg::BIT_FIRST;
      shreg    <= 8'h00;
      ack_pend <= 1'b0;
    end else begin
      state <= next_state;
      if (bit_cnt != mis_pkg::BIT_ACK) begin
        shreg   <= byte_in;
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == mis_pkg::BIT_LAST) begin
          ack_pend <= next_ack;
        end
      end else begin
        bit_cnt  <= mis_pkg::BIT_FIRST;
        ack_pend <= 1'b0;
      end
    end
  end

  // pointer and write word survive START/STOP; power-up clears both, a general call reset clears ptr
  always_ff @(posedge scl or posedge link_por) begin
    if (link_por) begin
      ptr     <= mis_pkg::PTR_RESET;
      wr_hi   <= 8'h00;
      wr_data <= mis_pkg::WORD_RESET;
      ev_tog  <= '0;
    end else begin
      if (gc_fire) begin
        ptr <= mis_pkg::PTR_RESET;
      end else if (ptr_load) begin
        ptr <= byte_in;
      end
      if (bit_cnt == mis_pkg::BIT_LAST && state == mis_pkg::ST_DATA_HI) begin
        wr_hi <= byte_in;
      end
      if (wr_fire) begin
        wr_data <= {wr_hi, byte_in};
      end
      ev_tog <= ev_tog ^ {gc_fire, hs_fire, wr_fire, ptr_load};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: sda drive on falling scl

  assign tx_byte = (state == mis_pkg::ST_RD_HI) ? rd_snap[15:8] : rd_snap[7:0];

  always_ff @(negedge scl or posedge link_clr) begin
    if (link_clr) begin
      sda_oe_n <= 1'b1;
      tx_sh    <= 8'h00;
    end else if (bit_cnt == mis_pkg::BIT_ACK) begin
      sda_oe_n <= ~ack_pend;
    end else if (state == mis_pkg::ST_RD_HI || state == mis_pkg::ST_RD_LO) begin
      if (bit_cnt == mis_pkg::BIT_FIRST) begin
        tx_sh    <= {tx_byte[6:0], 1'b0};
        sda_oe_n <= tx_byte[7];
      end else begin
        tx_sh    <= {tx_sh[6:0], 1'b0};
        sda_oe_n <= tx_sh[7];
      end
    end else begin
      sda_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: pin synchronisers and bus conditions

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_s1 <= 4'hF;
      pin_s2 <= 4'hF;
      pin_s3 <= 4'hF;
      ev_s1  <= '0;
      ev_s2  <= '0;
      ev_s3  <= '0;
    end else begin
      pin_s1 <= {addr_select_high_pin, addr_select_low_pin, sda_in, scl};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      ev_s1  <= ev_tog;
      ev_s2  <= ev_s1;
      ev_s3  <= ev_s2;
    end
  end

  assign scl_s     = pin_s2[0];
  assign sda_s     = pin_s2[1];
  assign scl_p     = pin_s3[0];
  assign sda_p     = pin_s3[1];
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign scl_rise  = scl_s & ~scl_p;
  assign ev_pulse  = ev_s2 ^ ev_s3;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: address straps

  // first look at START (scl high, sda low), second just before the first
  // scl rise (scl low, sda high from the leading 1 of the address)
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sel_a    <= 2'h0;
      want_b   <= 1'b0;
      own_addr <= mis_pkg::ADDR_RESET;
    end else if (start_det) begin
      sel_a  <= pin_s2[3:2];
      want_b <= 1'b1;
    end else if (want_b && scl_rise) begin
      want_b   <= 1'b0;
      own_addr <= {mis_pkg::ADDR_FIXED,
                   sel_a[1] ^ pin_s3[3], sel_a[1],
                   sel_a[0] ^ pin_s3[2], sel_a[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: bus-lock timeout

  assign bus_low = ~scl_s | ~sda_s;
  assign to_fire = bus_low & (low_cnt == TO_LAST);

  // saturates so one lock-up gives one reset pulse
  always_ff @(posedge sys_clk) begin
    if (!resetn || !bus_low) begin
      low_cnt <= '0;
    end else if (low_cnt != TO_LAST + 1'b1) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: link resets and mode

  // link_clr is a flop, so the async clear of the link logic is glitch free
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      link_clr <= 1'b1;
      link_por <= 1'b1;
    end else begin
      link_clr <= start_det | stop_det | to_fire;
      link_por <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hs_mode <= 1'b0;
    end else if (ev_pulse[mis_pkg::EV_HS]) begin
      hs_mode <= 1'b1;
    end else if (stop_det || to_fire || ev_pulse[mis_pkg::EV_GC]) begin
      hs_mode <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= ev_pulse[mis_pkg::EV_GC];
    end
  end

  // sda is open drain: the data level is always low, only the enable moves
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: register file hand-off

  // ptr and wr_data are held in the link domain until the next event toggle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_ptr <= mis_pkg::PTR_RESET;
    end else if (ev_pulse[mis_pkg::EV_PTR] || ev_pulse[mis_pkg::EV_GC]) begin
      reg_ptr <= ptr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_wr <= '0;
    end else begin
      reg_wr.valid <= ev_pulse[mis_pkg::EV_WR];
      if (ev_pulse[mis_pkg::EV_WR]) begin
        reg_wr.ptr  <= ptr;
        reg_wr.data <= wr_data;
      end
    end
  end

  // snapshot at START so the link never sees a word change mid byte
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_snap <= mis_pkg::WORD_RESET;
    end else if (start_det) begin
      rd_snap <= rd_data;
    end
  end

endmodule // mis_slave_port

// *** tb/mis_monitor.sv ***
`timescale 1ns/100ps
module mis_monitor #(
  parameter int unsigned TIMEOUT_CYCLES = 2000
) (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  // bus
  input wire logic                 scl,
  input wire logic                 sda_in,
  input wire logic                 sda_out,
  input wire logic                 sda_oe_n,
  // register side and mode
  input wire logic [7:0]           reg_ptr,
  input wire mis_pkg::mis_wr_req_t reg_wr,
  input wire logic                 hs_mode,
  input wire logic                 soft_reset
);
  logic [31:0] low_cnt;
  // either line low counts toward the lock-up limit
  always_ff @(posedge sys_clk) begin
    if (!resetn || (scl && sda_in)) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= low_cnt + 32'h1;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_stop;
    (scl && !sda_in) ##1 (scl && sda_in);
  endsequence
  sequence s_idle;
    ##[1:8] (sda_oe_n && !hs_mode);
  endsequence
  chk_sda_od_only: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  chk_wr_one_pulse: assert property (reg_wr.valid |=> !reg_wr.valid)
    else $error("write strobe too long");
  chk_wr_ptr_match: assert property (reg_wr.valid |-> reg_wr.ptr == reg_ptr)
    else $error("write target differs from pointer");
  chk_wr_data_hold: assert property ($changed(reg_wr.data) |->
    reg_wr.valid || soft_reset || $past(soft_reset)) else $error("write data moved");
  chk_soft_one_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset too long");
  chk_soft_clears: assert property (soft_reset |->
    ##[0:4] (reg_ptr == 8'h00 && !hs_mode)) else $error("soft reset left state");
  chk_stop_idle: assert property (s_stop |-> s_idle)
    else $error("stop did not idle the port");
  chk_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl)
    else $error("sda pulled while scl high");
  chk_lock_release: assert property (low_cnt > TIMEOUT_CYCLES + 8 |->
    sda_oe_n && !hs_mode) else $error("lock-up not cleared");
endmodule // mis_monitor

bind mis_slave_port mis_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_mis_monitor (
  .sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
  .hs_mode(hs_mode), .soft_reset(soft_reset));

// *** tb/mis_mst.sv ***
`timescale 1ns/100ps
module mis_mst #(
  parameter int unsigned HALF_NS = 1260
) (
  // lines the master drives
  output logic      scl,
  output logic      sda_rel,
  // resolved wire
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  ////////////////////////////////////////
  task automatic start();
    sda_rel = 1'b1;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_rel = 1'b0;
    #(HALF_NS);
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_rel = 1'b1;
    #(HALF_NS);
  endtask
  // data moves only while scl is low; rate kept at 400 kHz or below
  task automatic clk_bit(input logic b, output logic r);
    sda_rel = b;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(v[i], r);
    clk_bit(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(nack, r);
  endtask
endmodule // mis_mst

// *** tb/mis_slave_port_tb.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module mis_slave_port_tb;
  localparam int unsigned TO = 4000;
  logic                 sys_clk;
  logic                 resetn;
  logic                 scl;
  logic                 sda_rel;
  logic                 sda_out;
  logic                 sda_oe_n;
  logic [1:0]           sel_lo;
  logic [1:0]           sel_hi;
  logic [7:0]           reg_ptr;
  logic [7:0]           d;
  logic                 hs_mode;
  logic                 soft_reset;
  mis_pkg::mis_wr_req_t reg_wr;
  mis_pkg::mis_wr_req_t last_wr;
  wire                  sda;
  wire                  pin_lo;
  wire                  pin_hi;
  int                   n_fail = 0;
  int                   checked = 0;
  int                   wr_cnt = 0;
  int                   gc_cnt = 0;
  // pull-up: the wire is high unless someone pulls it
  assign sda = sda_rel & (sda_oe_n | sda_out);
  assign pin_lo = (sel_lo == 2'h2) ? sda : (sel_lo == 2'h3) ? scl : sel_lo[0];
  assign pin_hi = (sel_hi == 2'h2) ? sda : (sel_hi == 2'h3) ? scl : sel_hi[0];
  mis_slave_port #(.TIMEOUT_CYCLES(TO)) i_mis_slave_port (
    .sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_low_pin(pin_lo),
    .addr_select_high_pin(pin_hi), .reg_ptr(reg_ptr), .rd_data({reg_ptr, ~reg_ptr}),
    .reg_wr(reg_wr), .hs_mode(hs_mode), .soft_reset(soft_reset));
  mis_mst i_mis_mst (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (reg_wr.valid === 1'b1) begin
      wr_cnt++;
      last_wr = reg_wr;
    end
    if (soft_reset === 1'b1) gc_cnt++;
  end
  task automatic sta(); i_mis_mst.start(); endtask
  task automatic sto(); i_mis_mst.stop(); repeat (10) @(negedge sys_clk); endtask
  task automatic wb(input logic [7:0] v, input logic exp);
    logic a;
    i_mis_mst.wr_byte(v, a);
    `CHK(a, exp)
  endtask
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_addr();
    for (int c = 0; c < 16; c++) begin
      sel_lo = c[1:0];
      sel_hi = c[3:2];
      sta();
      wb({3'h4, c[3:0], 1'b0}, 1'b0);
      sto();
      if (c[1:0] == 2'h3) begin
        sta();
        wb({3'h4, c[3:0] ^ 4'h5, 1'b0}, 1'b1);
        sto();
      end
    end
    sel_lo = 2'h0;
    sel_hi = 2'h0;
    $display("addr done");
  endtask
  task automatic t_write();
    sta();
    wb(8'h80, 1'b0);
    wb(8'h05, 1'b0);
    wb(8'h12, 1'b0);
    wb(8'h34, 1'b0);
    wb(8'h56, 1'b1);
    sto();
    `CHK(wr_cnt, 1)
    `CHK(last_wr.ptr, 8'h05)
    `CHK(last_wr.data, 16'h1234)
    $display("write done");
  endtask
  task automatic t_read();
    sta();
    wb(8'h80, 1'b0);
    wb(8'hA5, 1'b0);
    sto();
    `CHK(wr_cnt, 1)
    for (int i = 0; i < 2; i++) begin
      sta();
      wb(8'h81, 1'b0);
      i_mis_mst.rd_byte(i[0], d);
      `CHK(d, 8'hA5)
      if (i == 0) begin
        i_mis_mst.rd_byte(1'b1, d);
        `CHK(d, 8'h5A)
      end else begin
        repeat (30) @(negedge sys_clk);
        `CHK(sda_oe_n, 1'b1)
      end
      sto();
      `CHK(reg_ptr, 8'hA5)
    end
    $display("read done");
  endtask
  task automatic t_abandon();
    sta();
    wb(8'h80, 1'b0);
    wb(8'h44, 1'b0);
    wb(8'h99, 1'b0);
    sta();
    wb(8'h80, 1'b0);
    wb(8'h33, 1'b0);
    wb(8'h77, 1'b0);
    sto();
    `CHK(wr_cnt, 1)
    `CHK(reg_ptr, 8'h33)
    $display("abandon done");
  endtask
  task automatic t_hs();
    for (int k = 0; k < 2; k++) begin
      sta();
      wb(k == 0 ? 8'h08 : 8'h0F, 1'b1);
      `CHK(hs_mode, 1'b1)
      sta();
      wb(8'h80, 1'b0);
      `CHK(hs_mode, 1'b1)
      sto();
      `CHK(hs_mode, 1'b0)
    end
    sta();
    wb(8'h00, 1'b0);
    wb(8'h05, 1'b1);
    sto();
    `CHK(gc_cnt, 0)
    sta();
    wb(8'h0A, 1'b1);
    sta();
    wb(8'h00, 1'b0);
    wb(8'h06, 1'b0);
    sto();
    `CHK(gc_cnt, 1)
    `CHK(reg_ptr, 8'h00)
    $display("mode and general call done");
  endtask
  task automatic t_lock();
    logic r;
    sta();
    wb(8'h08, 1'b1);
    `CHK(hs_mode, 1'b1)
    sta();
    for (int i = 7; i >= 0; i--)
      i_mis_mst.clk_bit(i == 7, r);
    repeat (30) @(negedge sys_clk);
    `CHK(sda_oe_n, 1'b0)
    repeat (TO + 100) @(negedge sys_clk);
    `CHK(sda_oe_n, 1'b1)
    `CHK(hs_mode, 1'b0)
    sto();
    sta();
    wb(8'h80, 1'b0);
    sto();
    $display("lock-up done");
  endtask
  ////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    sel_lo = 2'h0;
    sel_hi = 2'h0;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_addr();
    t_write();
    t_read();
    t_abandon();
    t_hs();
    t_lock();
    complete_run();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
endmodule // mis_slave_port_tb
